// ==== rtl/dps_core.sv ====
// phase-to-sine synthesis core with sample fifo
// Functional notes
// - buffer register loads on buffer clock rising edge only when load enable high
// - load enable low: buffer register holds regardless of buffer clock edges
// - format select high: all 32 tuning bits load in parallel
// - format select low: shift one bit per edge, new bit from input bit 31
// - transfer enable high copies the mirrored buffer word (after the launch handshake) into frequency register next system edge
// - everything except buffer loading and word launch runs on the system clock
// - 32-bit accumulator feeds 15-bit phase to 12-bit amplitude converter
// - dither off: external carry adds one lsb into the accumulator adder
// - dither on: external carry ignored, carry-in alternates on each accumulator advance
// - output format select high gives two's complement samples
// - output format select low gives unsigned offset magnitude samples
// - samples registered, valid strobe marks each new sample
// - new tuning word reaches outputs 14 system cycles after transfer while output ready stays high and the fifo holds one sample
// - sample and strobe outputs held in system-clocked output latches
// - phase clear high zeroes the accumulator synchronously
// - adder carry-out is driven out for chaining to 64 bits
// - converter uses only the 15 accumulator msbs
`timescale 1ns/1ps

module dps_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [CW-1:0] next_count;
  logic push;
  logic pop;

  assign in_ready = (count != FULL_COUNT);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    next_count = count;
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule

module dps_core (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic buffer_load_clock,
  input wire logic buffer_load_enable,
  input wire logic load_format_select,
  input wire logic [0:dps_pkg::TW_W-1] tuning_word_in,
  input wire logic tuning_transfer_enable,
  input wire logic carry_input,
  input wire logic carry_dither_enable,
  input wire logic phase_clear,
  input wire logic output_format_select,
  input wire logic output_ready,
  output logic [0:dps_pkg::AMP_W-1] amplitude_out,
  output logic output_valid_strobe,
  output logic carry_output
);
  import dps_pkg::*;

  // ------------------------------------------------------------------
  // converter: half-wave parabola, offset code
  // ------------------------------------------------------------------
  function automatic logic [AMP_W-1:0] sine_code(input logic [PH_W-1:0] p);
    logic [13:0] u;
    logic [14:0] v;
    logic [28:0] prod;
    logic [39:0] scaled;
    logic [MAG_W-1:0] mag;
    u = p[13:0];
    v = HALF_SPAN - {1'b0, u};
    prod = 29'(u) * 29'(v);
    scaled = 40'(prod) * 40'(AMP_PEAK);
    mag = scaled[SINE_SHIFT +: MAG_W];
    sine_code = p[PH_W-1] ? AMP_MID - {1'b0, mag} : AMP_MID + {1'b0, mag};
  endfunction

  // ------------------------------------------------------------------
  // link domain: buffer register and word launch
  // ------------------------------------------------------------------
  logic [TW_W-1:0] buffer;
  logic [TW_W-1:0] xfer_word;
  logic dirty;
  logic req;
  logic ack_s1;
  logic ack_s2;
  logic ack;
  logic [TW_W-1:0] next_buffer;
  logic [TW_W-1:0] next_xfer_word;
  logic next_dirty;
  logic next_req;
  logic launch;
  logic [TW_W-1:0] word_in;

  assign word_in = tuning_word_in;
  assign launch = dirty && (req == ack_s2);

  always_comb begin
    next_buffer = buffer;
    if (buffer_load_enable) begin
      if (load_format_select) begin
        next_buffer = word_in;
      end else begin
        next_buffer = {buffer[TW_W-2:0], tuning_word_in[TW_W-1]};
      end
    end
    next_xfer_word = launch ? buffer : xfer_word;
    next_req = launch ? ~req : req;
    // a load in the launch cycle keeps the word marked pending
    next_dirty = buffer_load_enable ? 1'b1 : (launch ? 1'b0 : dirty);
  end

  always_ff @(posedge buffer_load_clock or negedge rst_n) begin
    if (!rst_n) begin
      buffer <= TW_RST;
      xfer_word <= TW_RST;
      dirty <= 1'b0;
      req <= 1'b0;
      ack_s1 <= 1'b0;
      ack_s2 <= 1'b0;
    end else begin
      buffer <= next_buffer;
      xfer_word <= next_xfer_word;
      dirty <= next_dirty;
      req <= next_req;
      ack_s1 <= ack;
      ack_s2 <= ack_s1;
    end
  end

  // ------------------------------------------------------------------
  // system domain: word capture and frequency register
  // ------------------------------------------------------------------
  logic req_s1;
  logic req_s2;
  logic [TW_W-1:0] mirror;
  logic [TW_W-1:0] freq;
  logic [TW_W-1:0] next_mirror;
  logic [TW_W-1:0] next_freq;
  logic next_ack;

  always_comb begin
    // xfer_word is held stable until the ack returns
    next_mirror = (req_s2 != ack) ? xfer_word : mirror;
    next_ack = req_s2;
    next_freq = tuning_transfer_enable ? mirror : freq;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      ack <= 1'b0;
      mirror <= TW_RST;
      freq <= TW_RST;
    end else begin
      req_s1 <= req;
      req_s2 <= req_s1;
      ack <= next_ack;
      mirror <= next_mirror;
      freq <= next_freq;
    end
  end

  // ------------------------------------------------------------------
  // phase accumulator
  // ------------------------------------------------------------------
  logic [TW_W-1:0] phase;
  logic dither;
  logic advance;
  logic carry_in_sel;
  logic [TW_W:0] sum;
  logic [TW_W-1:0] next_phase;
  logic next_dither;
  logic next_carry_output;

  assign carry_in_sel = carry_dither_enable ? dither : carry_input;
  assign sum = {1'b0, phase} + {1'b0, freq} + {{TW_W{1'b0}}, carry_in_sel};

  always_comb begin
    next_phase = phase;
    next_carry_output = carry_output;
    next_dither = dither;
    if (advance) begin
      next_phase = sum[TW_W-1:0];
      next_carry_output = sum[TW_W];
      next_dither = ~dither;
    end
    if (phase_clear) begin
      next_phase = TW_RST;
      next_carry_output = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase <= TW_RST;
      carry_output <= 1'b0;
      dither <= 1'b0;
    end else begin
      phase <= next_phase;
      carry_output <= next_carry_output;
      dither <= next_dither;
    end
  end

  // ------------------------------------------------------------------
  // converter pipeline
  // ------------------------------------------------------------------
  logic [AMP_W-1:0] pipe [PIPE_STAGES];
  logic [AMP_W-1:0] next_pipe [PIPE_STAGES];

  always_comb begin
    for (int i = 0; i < PIPE_STAGES; i++) begin
      next_pipe[i] = pipe[i];
    end
    if (advance) begin
      next_pipe[0] = sine_code(phase[TW_W-1:PH_LSB]);
      for (int i = 1; i < PIPE_STAGES; i++) begin
        next_pipe[i] = pipe[i-1];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < PIPE_STAGES; i++) begin
        pipe[i] <= AMP_RST;
      end
    end else begin
      for (int i = 0; i < PIPE_STAGES; i++) begin
        pipe[i] <= next_pipe[i];
      end
    end
  end

  // ------------------------------------------------------------------
  // sample fifo and output latch
  // ------------------------------------------------------------------
  logic fifo_out_valid;
  logic [AMP_W-1:0] fifo_out_data;
  logic pop;
  logic [AMP_W-1:0] amp;
  logic [AMP_W-1:0] next_amp;
  logic next_strobe;

  dps_fifo #(
    .WIDTH(AMP_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_valid(1'b1),
    .in_ready(advance),
    .in_data(pipe[PIPE_STAGES-1]),
    .out_valid(fifo_out_valid),
    .out_ready(output_ready),
    .out_data(fifo_out_data)
  );

  assign pop = fifo_out_valid && output_ready;
  assign amplitude_out = amp;

  always_comb begin
    next_amp = amp;
    if (pop) begin
      next_amp = fifo_out_data;
      if (output_format_select) begin
        // offset code to two's complement is an msb flip
        next_amp = fifo_out_data ^ AMP_MID;
      end
    end
    next_strobe = pop;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      amp <= AMP_RST;
      output_valid_strobe <= 1'b0;
    end else begin
      amp <= next_amp;
      output_valid_strobe <= next_strobe;
    end
  end
endmodule

// ==== rtl/dps_pkg.sv ====
// shared constants for the phase-to-sine synthesis core
package dps_pkg;
  // ------------------------------------------------------------------
  // widths
  // ------------------------------------------------------------------
  localparam int TW_W = 32;
  localparam int PH_W = 15;
  localparam int AMP_W = 12;
  localparam int MAG_W = 11;
  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int PH_LSB = TW_W - PH_W;
  localparam int SINE_SHIFT = 26;
  // ------------------------------------------------------------------
  // timing and depths
  // ------------------------------------------------------------------
  localparam int LATENCY = 14;
  localparam int PIPE_STAGES = LATENCY - 3;
  localparam int FIFO_DEPTH = 16;
  // ------------------------------------------------------------------
  // values and reset values
  // ------------------------------------------------------------------
  localparam logic [AMP_W-1:0] AMP_MID = 12'h800;
  localparam logic [MAG_W-1:0] AMP_PEAK = 11'h7ff;
  localparam logic [14:0] HALF_SPAN = 15'h4000;
  localparam logic [TW_W-1:0] TW_RST = 32'h0000_0000;
  localparam logic [AMP_W-1:0] AMP_RST = 12'h800;
endpackage

// ==== sim/dps_core_sva.sv ====
// port-level assertions for the synthesis core
`timescale 1ns/1ps
module dps_core_sva (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic phase_clear,
  input wire logic output_format_select,
  input wire logic output_ready,
  input wire logic [0:dps_pkg::AMP_W-1] amplitude_out,
  input wire logic output_valid_strobe,
  input wire logic carry_output
);
  import dps_pkg::*;
  logic [5:0] clr_cnt, next_clr_cnt, stl_cnt, next_stl_cnt;
  logic [1:0] rel_cnt, next_rel_cnt;
  logic fmt_q;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // ------------------------------------------------------------------
  // run-length counters
  // ------------------------------------------------------------------
  always_comb begin
    next_clr_cnt = clr_cnt + {5'h00, clr_cnt != 6'h3f};
    if (!phase_clear || !output_ready || fmt_q != output_format_select) begin
      next_clr_cnt = 6'h00;
    end
    next_stl_cnt = stl_cnt + {5'h00, stl_cnt != 6'h3f};
    if (output_ready || phase_clear) begin
      next_stl_cnt = 6'h00;
    end
    next_rel_cnt = rel_cnt + {1'b0, rel_cnt != 2'h3};
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      clr_cnt <= 6'h00;
      stl_cnt <= 6'h00;
      rel_cnt <= 2'h0;
      fmt_q <= 1'b0;
    end else begin
      clr_cnt <= next_clr_cnt;
      stl_cnt <= next_stl_cnt;
      rel_cnt <= next_rel_cnt;
      fmt_q <= output_format_select;
    end
  end
  // ------------------------------------------------------------------
  // properties
  // ------------------------------------------------------------------
  a_strobe_cause: assert property (output_valid_strobe |-> $past(output_ready))
    else $error("strobe without a taken sample");
  a_amp_latched: assert property ($changed(amplitude_out) |-> output_valid_strobe)
    else $error("sample changed without strobe");
  a_stall_quiet: assert property (!output_ready |=> $stable(amplitude_out))
    else $error("sample changed while stalled");
  a_flow_steady: assert property (output_ready [*8] |-> output_valid_strobe)
    else $error("strobe missing in steady flow");
  a_clear_carry: assert property (phase_clear |=> !carry_output)
    else $error("carry out after phase clear");
  a_clear_mid: assert property (clr_cnt >= 6'h28 |->
    amplitude_out == (fmt_q ? 12'h000 : AMP_MID))
    else $error("cleared phase not at zero amplitude");
  a_stall_freeze: assert property (stl_cnt >= 6'h28 |->
    $stable(carry_output) && $stable(amplitude_out))
    else $error("accumulator moved while full");
  a_reset_idle: assert property (rel_cnt == 2'h1 |->
    !output_valid_strobe && amplitude_out == AMP_RST)
    else $error("outputs not idle after reset");
  c_clear_run: cover property (clr_cnt == 6'h28);
  c_stall_run: cover property (stl_cnt == 6'h28);
  c_strobe: cover property ($rose(output_valid_strobe));
endmodule
bind dps_core dps_core_sva u_sva (.clock(clock), .rst_n(rst_n), .phase_clear(phase_clear),
  .output_format_select(output_format_select), .output_ready(output_ready),
  .amplitude_out(amplitude_out), .output_valid_strobe(output_valid_strobe),
  .carry_output(carry_output));

// ==== sim/dps_core_tb_top.sv ====
// self-checking bench for the synthesis core
`timescale 1ns/1ps
module dps_core_tb_top;
  import dps_pkg::*;
  logic clock = 1'b0;
  logic lclk = 1'b0;
  logic rst_n = 1'b0;
  logic ld_en = 1'b0, ld_par = 1'b0, xfer = 1'b0, cy_in = 1'b0;
  logic dith = 1'b0, clr = 1'b0, fmt = 1'b0, rdy, strb, cy_out;
  logic [0:TW_W-1] tw = '0;
  logic [0:AMP_W-1] amp;
  logic [1:0] mode = 2'h0;
  logic [31:0] w;
  int seed = 32'h135b922f;
  int fail_count = 0, comparisons = 0, taken, given, t0, g0;
  always #2.5 clock = ~clock;
  initial #1.3 forever #7.5 lclk = ~lclk;
  dps_core uut (.clock(clock), .rst_n(rst_n), .buffer_load_clock(lclk),
    .buffer_load_enable(ld_en), .load_format_select(ld_par), .tuning_word_in(tw),
    .tuning_transfer_enable(xfer), .carry_input(cy_in), .carry_dither_enable(dith),
    .phase_clear(clr), .output_format_select(fmt), .output_ready(rdy),
    .amplitude_out(amp), .output_valid_strobe(strb), .carry_output(cy_out));
  dps_sink u_sink (.clock(clock), .rst_n(rst_n), .mode(mode), .output_valid_strobe(strb),
    .output_ready(rdy), .taken(taken), .given(given));
  // ------------------------------------------------------------------
  // compare, load and measure tasks
  // ------------------------------------------------------------------
  task automatic chk_amp(input logic [0:AMP_W-1] got, input logic [0:AMP_W-1] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected sample at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected count at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // carry-outs over 256 steps from a cleared phase
  function automatic logic [31:0] exp_carries(input logic [31:0] v, input bit d, input bit c);
    longint t;
    t = longint'(v) * 256 + (d ? 128 : (c ? 256 : 0));
    exp_carries = 32'(t >> 32);
  endfunction
  // unsigned is midscale plus magnitude, signed is that less midscale
  function automatic logic [0:AMP_W-1] exp_sample(input bit f, input bit peak);
    logic [AMP_W-1:0] u;
    u = peak ? AMP_MID + {1'b0, AMP_PEAK} : AMP_MID;
    exp_sample = f ? u - AMP_MID : u;
  endfunction
  // serial words go in msb first through the lsb input
  task automatic load(input logic [31:0] v, input bit par);
    for (int i = 0; i < (par ? 1 : 32); i++) begin
      @(posedge lclk);
      ld_en <= 1'b1;
      ld_par <= par;
      tw <= par ? v : (32'($random(seed)) & 32'hffff_fffe) | {31'h0, v[31-i]};
    end
    @(posedge lclk);
    ld_en <= 1'b0;
    repeat (9) begin
      @(posedge lclk);
      tw <= 32'($random(seed));
      ld_par <= 1'($random(seed));
    end
  endtask
  task automatic transfer;
    @(posedge clock);
    xfer <= 1'b1;
    @(posedge clock);
    xfer <= 1'b0;
  endtask
  // carries in 256 steps from a cleared phase
  task automatic measure(input logic [31:0] v, input bit d, input bit c);
    logic [31:0] n;
    n = 32'h0;
    @(posedge clock);
    clr <= 1'b1;
    dith <= d;
    cy_in <= c;
    repeat (2) @(posedge clock);
    clr <= 1'b0;
    repeat (256) begin
      @(posedge clock);
      if (d) cy_in <= 1'($random(seed));
      #1 n = n + {31'h0, cy_out};
    end
    chk_cnt(n, exp_carries(v, d, c));
  endtask
  task automatic latency(input bit f);
    @(posedge clock);
    clr <= 1'b1;
    fmt <= f;
    repeat (40) @(posedge clock);
    xfer <= 1'b1;
    @(posedge clock);
    xfer <= 1'b0;
    clr <= 1'b0;
    for (int k = 1; k <= LATENCY; k++) begin
      @(posedge clock);
      #1 chk_amp(amp, exp_sample(f, k == LATENCY));
    end
  endtask
  // ------------------------------------------------------------------
  // main sequence and watchdog
  // ------------------------------------------------------------------
  initial begin
    #200000;
    fail_count++;
    conclude;
  end
  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    load(32'h4000_0000, 1'b1);
    latency(1'b0);
    latency(1'b1);
    for (int i = 0; i < 8; i++) begin
      w = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0 : 32'($random(seed));
      load(w, i[0]);
      transfer;
      load(32'($random(seed)), !i[0]);
      measure(w, i[1], i == 0 || 1'($random(seed)));
    end
    mode <= 2'h2;
    repeat (4) @(posedge clock);
    t0 = taken;
    g0 = given;
    mode <= 2'h1;
    repeat (300) @(posedge clock);
    mode <= 2'h2;
    repeat (60) @(posedge clock);
    chk_cnt(32'(taken - t0), 32'(given - g0));
    mode <= 2'h0;
    rst_n <= 1'b0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    repeat (2) @(posedge clock);
    w = 32'($random(seed));
    load(w, 1'b0);
    transfer;
    measure(w, 1'b0, 1'b0);
    conclude;
  end
endmodule

// ==== sim/dps_sink.sv ====
// sample sink standing in for the converter fed by the core
`timescale 1ns/1ps
module dps_sink (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [1:0] mode,
  input wire logic output_valid_strobe,
  output logic output_ready,
  output int taken,
  output int given
);
  int seed = 32'h135b922f;
  // mode 0 prompt, 1 sparse random, 2 halted
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      output_ready <= 1'b1;
      taken <= 0;
      given <= 0;
    end else begin
      taken <= taken + int'(output_valid_strobe);
      given <= given + int'(output_ready);
      output_ready <= mode == 2'h0 || (mode == 2'h1 && $random(seed) % 8 == 0);
    end
  end
endmodule
